/* File: logic/mpfc_pkg.sv */
// Shared constants for the pause flow-control block.
`default_nettype none
package mpfc_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    // Control register bit positions.
    localparam int CTRL_TX_NEW = 0;
    localparam int CTRL_TX_TIMER = 1;
    localparam int CTRL_RX_LINK = 2;
    localparam int CTRL_RX_PRIO = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // Status register bit positions.
    localparam int STAT_PAUSED = 0;
    localparam int STAT_PEND_LINK = 1;
    localparam int STAT_PEND_PRIO = 2;
    localparam int STAT_REQ = 3;
    localparam int STAT_RX_LINK = 4;
    localparam int STAT_RX_PRIO = 8;
    // Geometry.
    localparam int NUM_PRIO = 8;
    localparam int TIME_W = 16;
    // One pause quantum is 512 UI; at 10 Gb/s that is 51200 ps.
    localparam int unsigned CLK_PERIOD_PS = 10000;
    localparam int unsigned QUANTUM_PS = 51200;
    localparam int unsigned QUANTUM_CYCLES =
        (QUANTUM_PS / CLK_PERIOD_PS) < 1 ? 1 : (QUANTUM_PS / CLK_PERIOD_PS);
    localparam logic [7:0] PRE_LAST = 8'(QUANTUM_CYCLES - 1);
endpackage : mpfc_pkg
`default_nettype wire

/* File: logic/mpfc_quanta_timer.sv */
// Pause-time countdown counted in 512 UI quanta.
`default_nettype none
module mpfc_quanta_timer
    import mpfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [TIME_W-1:0] value_i,
    output logic running_o,
    output logic expire_o
);
    logic [7:0] pre_r;
    logic [7:0] pre_nxt;
    logic [TIME_W-1:0] cnt_r;
    logic [TIME_W-1:0] cnt_nxt;
    logic expire_r;
    logic expire_nxt;
    wire tick = (pre_r == PRE_LAST);

    // A load restarts the quantum so the first quantum is never short.
    assign pre_nxt = (load_i || tick) ? 8'h00 : 8'(pre_r + 8'h01);
    assign cnt_nxt = load_i ? value_i :
        (tick && cnt_r != 16'h0000) ? 16'(cnt_r - 16'h0001) : cnt_r;
    assign expire_nxt = !load_i && tick && (cnt_r == 16'h0001);
    assign running_o = (cnt_r != 16'h0000);
    assign expire_o = expire_r;

    // Counter state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= 8'h00;
            cnt_r <= 16'h0000;
            expire_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            expire_r <= expire_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    quanta_hold_a: assert property (!load_i && !tick |=> cnt_r == $past(cnt_r))
        else $error("timer moved inside a quantum");
    quanta_step_a: assert property (!load_i && tick && running_o |=> cnt_r == 16'($past(cnt_r) - 16'h0001))
        else $error("timer did not step at quantum end");
endmodule : mpfc_quanta_timer
`default_nettype wire

/* File: logic/mpfc_top.sv */
// Pause flow control: transmit pause origination, halt, receive pause status.
// Functional notes
// - Send strobe pulse sends one pause frame.
// - Beat enable plus options sends repeated frames.
// - Beat interval is 16 bits of quanta.
// - Link frames need port enable and option.
// - Link frame carries configured port pause time.
// - Priority frames enabled per 8-bit vector.
// - Priority times are 16-bit slices, low first.
// - Link XOFF level change sends link frame.
// - Link XOFF low sends zero, high sends time.
// - Priority XOFF bit change sends priority frame.
// - Priority timer zero when its XOFF low.
// - Halt request stops packet transmission.
// - Paused output shows transmission is halted.
// - Own reset clears receive pause logic.
// - Link pause frames processed only when enabled.
// - Priority pause frames processed per enabled priority.
// - Link XOFF status after nonzero link pause.
// - Priority XOFF status bit per active priority.
// - Pause frame flagged in error bit zero.
`default_nettype none
module mpfc_top
    import mpfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pause_send_strobe_i,
    input wire logic beat_enable_i,
    input wire logic [15:0] beat_interval_i,
    input wire logic link_pause_enable_i,
    input wire logic [15:0] link_pause_time_i,
    input wire logic [7:0] prio_pause_enable_vec_i,
    input wire logic [127:0] prio_pause_time_vec_i,
    input wire logic link_xoff_request_i,
    input wire logic [7:0] priority_xoff_request_vec_i,
    input wire logic tx_halt_request_i,
    input wire logic tx_frame_busy_i,
    input wire logic pause_tx_ack_i,
    output logic pause_tx_req_o,
    output logic pause_tx_prio_o,
    output logic [15:0] pause_tx_time_o,
    output logic [7:0] pause_tx_class_vec_o,
    output logic [127:0] pause_tx_times_o,
    output logic tx_paused_o,
    input wire logic rx_flow_ctrl_sync_reset_i,
    input wire logic rx_link_pause_enable_i,
    input wire logic [7:0] rx_priority_pause_enable_vec_i,
    input wire logic rx_pause_valid_i,
    input wire logic rx_pause_is_prio_i,
    input wire logic [15:0] rx_pause_time_i,
    input wire logic [7:0] rx_pause_class_vec_i,
    input wire logic [127:0] rx_pause_times_i,
    input wire logic rx_end_of_packet_i,
    input wire logic rx_pause_detect_i,
    input wire logic [2:0] rx_other_error_i,
    output logic rx_link_xoff_status_o,
    output logic [7:0] rx_priority_xoff_status_vec_o,
    output logic rx_end_of_packet_o,
    output logic [3:0] rx_error_vector_o,
    output logic rx_error_summary_o
);
    // Picks one 16-bit pause time slice; slice 0 belongs to priority 0.
    function automatic logic [TIME_W-1:0] slice_of(input logic [127:0] v, input int idx);
        slice_of = v[idx*TIME_W +: TIME_W];
    endfunction : slice_of

    ////////////////////////////////////////////////////////////////////
    // Bus slave and control register.
    logic [3:0] ctrl_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic [31:0] stat_w;
    logic [31:0] rmux_w;
    // Address decode ignores bits 1:0; the option bits come straight from the control register.
    wire wb_hit = wb_cyc_i && wb_stb_i && !ack_r;
    wire ctrl_sel = (wb_adr_i[7:2] == CTRL_OFS[7:2]);
    wire stat_sel = (wb_adr_i[7:2] == STAT_OFS[7:2]);
    wire ctrl_wr = wb_hit && wb_we_i && ctrl_sel && wb_sel_i[0];
    wire tx_new = ctrl_r[CTRL_TX_NEW];
    wire tx_timer = ctrl_r[CTRL_TX_TIMER];
    wire rx_link_opt = ctrl_r[CTRL_RX_LINK];
    wire rx_prio_opt = ctrl_r[CTRL_RX_PRIO];

    // Unmapped addresses are acknowledged and read as zero.
    assign rmux_w = ctrl_sel ? {28'h0000000, ctrl_r} : (stat_sel ? stat_w : 32'h00000000);
    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;

    // One wait state: ack follows the request by one edge, then drops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            ack_r <= wb_hit;
            if (wb_hit) rdat_r <= rmux_w;
            if (ctrl_wr) ctrl_r <= wb_dat_i[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit triggers: strobe, beat timer and XOFF level changes.
    logic beat_exp_w;
    logic link_xoff_d_r;
    logic [7:0] prio_xoff_d_r;
    logic pend_link_r;
    logic pend_prio_r;
    logic [15:0] link_time_r;
    logic [15:0] link_time_nxt;
    // Triggers that arrive while a frame is already pending fold into that frame.
    wire beat_active = beat_enable_i && tx_new && tx_timer;
    wire beat_fire = beat_exp_w && beat_active;
    wire any_prio_en = |prio_pause_enable_vec_i;
    wire src_trig = tx_new && (pause_send_strobe_i || beat_fire);
    wire link_ok = tx_new && link_pause_enable_i;
    wire xoff_link_trig = link_ok && (link_xoff_request_i != link_xoff_d_r);
    wire xoff_prio_trig = tx_new && |((priority_xoff_request_vec_i ^ prio_xoff_d_r) & prio_pause_enable_vec_i);
    wire src_link_trig = src_trig && link_ok;
    wire src_prio_trig = src_trig && !link_ok && any_prio_en;
    wire link_trig = xoff_link_trig || src_link_trig;
    wire prio_trig = xoff_prio_trig || src_prio_trig;

    // The beat counter reloads while idle so the first beat waits a full interval.
    mpfc_quanta_timer u_beat (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(!beat_active || beat_exp_w),
        .value_i(beat_interval_i),
        .running_o(),
        .expire_o(beat_exp_w)
    );

    // An XOFF change sends its level; a strobe or beat sends the port time.
    assign link_time_nxt = xoff_link_trig ? (link_xoff_request_i ? link_pause_time_i : 16'h0000) :
        src_link_trig ? link_pause_time_i : link_time_r;

    ////////////////////////////////////////////////////////////////////
    // Issue queue: one frame handed out at a time, never mid-packet.
    logic req_r;
    logic prio_kind_r;
    logic [15:0] time_r;
    logic [7:0] class_r;
    logic [127:0] times_r;
    logic [127:0] prio_times_w;
    logic paused_r;
    // Link frames go first when both kinds are pending; nothing starts mid-packet.
    wire gap = !req_r && !tx_frame_busy_i;
    wire issue_link = gap && pend_link_r && link_ok;
    wire issue_prio = gap && pend_prio_r && tx_new && !(pend_link_r && link_ok);
    wire issue = issue_link || issue_prio;

    // Each priority timer is zero while its XOFF bit is low.
    always_comb begin
        prio_times_w = 128'h0;
        for (int i = 0; i < NUM_PRIO; i++) begin
            if (priority_xoff_request_vec_i[i]) begin
                prio_times_w[i*TIME_W +: TIME_W] = slice_of(prio_pause_time_vec_i, i);
            end
        end
    end

    // Pending flags: a new trigger wins over the clear from issuing.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_xoff_d_r <= 1'b0;
            prio_xoff_d_r <= 8'h00;
            pend_link_r <= 1'b0;
            pend_prio_r <= 1'b0;
            link_time_r <= 16'h0000;
        end else begin
            link_xoff_d_r <= link_xoff_request_i;
            prio_xoff_d_r <= priority_xoff_request_vec_i;
            pend_link_r <= link_trig || (pend_link_r && !issue_link);
            pend_prio_r <= prio_trig || (pend_prio_r && !issue_prio);
            link_time_r <= link_time_nxt;
        end
    end

    // Request stays up until the transmitter acknowledges it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_r <= 1'b0;
            prio_kind_r <= 1'b0;
            time_r <= 16'h0000;
            class_r <= 8'h00;
            times_r <= 128'h0;
        end else begin
            req_r <= issue || (req_r && !pause_tx_ack_i);
            if (issue) begin
                prio_kind_r <= !issue_link;
                time_r <= link_time_r;
                class_r <= prio_pause_enable_vec_i;
                times_r <= prio_times_w;
            end
        end
    end

    // Halt lands only between packets; a packet in flight is allowed to finish.
    always_ff @(posedge clk_i) begin
        if (rst_i) paused_r <= 1'b0;
        else paused_r <= tx_halt_request_i && (paused_r || !tx_frame_busy_i);
    end

    assign pause_tx_req_o = req_r;
    assign pause_tx_prio_o = prio_kind_r;
    assign pause_tx_time_o = time_r;
    assign pause_tx_class_vec_o = class_r;
    assign pause_tx_times_o = times_r;
    assign tx_paused_o = paused_r;

    ////////////////////////////////////////////////////////////////////
    // Receive pause processing; index 0 is the link timer, 1..8 priorities.
    logic [8:0] rx_load_w;
    logic [8:0] rx_run_w;
    logic [15:0] rx_val_w [0:8];
    logic rx_link_st_r;
    logic [7:0] rx_prio_st_r;
    logic rx_eop_r;
    logic [3:0] rx_err_r;
    logic rx_sum_r;
    wire rx_rst = rst_i || rx_flow_ctrl_sync_reset_i;
    wire pause_flag = rx_link_opt && rx_end_of_packet_i && rx_pause_detect_i;

    // Link pause frames load timer 0 only while both receive enables are on.
    assign rx_load_w[0] = rx_pause_valid_i && !rx_pause_is_prio_i && rx_link_pause_enable_i && rx_link_opt;
    assign rx_val_w[0] = rx_pause_time_i;

    // A zero time loads zero and so drops the status at once.
    for (genvar g = 0; g < 9; g++) begin : g_rx
        if (g > 0) begin : g_prio
            assign rx_load_w[g] = rx_pause_valid_i && rx_pause_is_prio_i && rx_prio_opt &&
                rx_pause_class_vec_i[g-1] && rx_priority_pause_enable_vec_i[g-1];
            assign rx_val_w[g] = slice_of(rx_pause_times_i, g - 1);
        end
        mpfc_quanta_timer u_rx (
            .clk_i(clk_i),
            .rst_i(rx_rst),
            .load_i(rx_load_w[g]),
            .value_i(rx_val_w[g]),
            .running_o(rx_run_w[g]),
            .expire_o()
        );
    end

    // Status and error flags, all cleared by the receive pause reset.
    always_ff @(posedge clk_i) begin
        if (rx_rst) begin
            rx_link_st_r <= 1'b0;
            rx_prio_st_r <= 8'h00;
            rx_eop_r <= 1'b0;
            rx_err_r <= 4'h0;
            rx_sum_r <= 1'b0;
        end else begin
            rx_link_st_r <= rx_run_w[0];
            rx_prio_st_r <= rx_run_w[8:1];
            rx_eop_r <= rx_end_of_packet_i;
            rx_err_r <= {rx_other_error_i, pause_flag};
            rx_sum_r <= pause_flag || |rx_other_error_i;
        end
    end

    assign rx_link_xoff_status_o = rx_link_st_r;
    assign rx_priority_xoff_status_vec_o = rx_prio_st_r;
    assign rx_end_of_packet_o = rx_eop_r;
    assign rx_error_vector_o = rx_err_r;
    assign rx_error_summary_o = rx_sum_r;

    // Status word; bits with no meaning read as zero.
    assign stat_w = {16'h0000, rx_prio_st_r, 3'h0, rx_link_st_r, req_r, pend_prio_r, pend_link_r, paused_r};

    ////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence link_change_s;
        link_ok && $changed(link_xoff_request_i);
    endsequence
    sequence link_pend_s;
        pend_link_r && (link_time_r == ($past(link_xoff_request_i) ? $past(link_pause_time_i) : 16'h0000));
    endsequence

    strobe_send_a: assert property (pause_send_strobe_i && link_ok |=> pend_link_r)
        else $error("strobe did not queue a frame");
    beat_send_a: assert property (beat_fire && (link_ok || any_prio_en) |=> pend_link_r || pend_prio_r)
        else $error("beat did not queue a frame");
    link_gate_a: assert property ($rose(req_r) && !prio_kind_r |-> $past(link_ok))
        else $error("link frame sent while disabled");
    link_time_a: assert property (issue_link |=> time_r == $past(link_time_r))
        else $error("link frame time mismatch");
    xoff_link_a: assert property (link_change_s |=> link_pend_s)
        else $error("link XOFF change lost or wrong time");
    xoff_prio_a: assert property (xoff_prio_trig |=> pend_prio_r)
        else $error("priority XOFF change lost");
    prio_time_a: assert property (issue_prio |=>
        times_r == $past(prio_times_w) && class_r == $past(prio_pause_enable_vec_i))
        else $error("priority frame contents wrong");
    halt_on_a: assert property (tx_halt_request_i && !tx_frame_busy_i |=> tx_paused_o)
        else $error("halt not shown");
    halt_off_a: assert property (!tx_halt_request_i |=> !tx_paused_o)
        else $error("paused without request");
    gap_only_a: assert property ($rose(req_r) |-> !$past(tx_frame_busy_i))
        else $error("pause frame issued during a packet");
    rx_link_on_a: assert property (disable iff (rx_rst)
        rx_load_w[0] && rx_pause_time_i != 16'h0000 |-> ##2 rx_link_xoff_status_o)
        else $error("link XOFF status not raised");
    rx_zero_off_a: assert property (disable iff (rx_rst)
        rx_load_w[0] && rx_pause_time_i == 16'h0000 |-> ##2 !rx_link_xoff_status_o)
        else $error("zero time did not clear status");
    rx_prio_on_a: assert property (disable iff (rx_rst)
        rx_load_w[1] && rx_pause_times_i[15:0] != 16'h0000 |-> ##2 rx_priority_xoff_status_vec_o[0])
        else $error("priority 0 XOFF status not raised");
    rx_reset_a: assert property (@(posedge clk_i) rx_flow_ctrl_sync_reset_i |=>
        !rx_link_xoff_status_o && rx_priority_xoff_status_vec_o == 8'h00)
        else $error("receive reset did not clear status");
    rx_err_flag_a: assert property (disable iff (rx_rst)
        rx_error_vector_o[0] |-> rx_end_of_packet_o && rx_error_summary_o)
        else $error("pause error flag outside end of packet");

    // Handshakes and gates that must hold whatever the stimulus does.
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    req_hold_a: assert property (req_r && !pause_tx_ack_i |=> req_r && $stable(time_r) && $stable(times_r))
        else $error("pause request dropped or changed before ack");
    halt_hold_a: assert property (tx_paused_o && tx_halt_request_i |=> tx_paused_o)
        else $error("paused dropped while halt still asked");
    rx_link_gate_a: assert property (disable iff (rx_rst)
        rx_pause_valid_i && !rx_link_pause_enable_i && !rx_run_w[0] |-> ##2 !rx_link_xoff_status_o)
        else $error("link pause frame processed while disabled");
    rx_prio_off_a: assert property (disable iff (rx_rst)
        rx_load_w[1] && rx_pause_times_i[15:0] == 16'h0000 |-> ##2 !rx_priority_xoff_status_vec_o[0])
        else $error("zero time did not clear priority 0 status");
    rx_err_gate_a: assert property (disable iff (rx_rst) rx_error_vector_o[0] |-> $past(rx_link_opt))
        else $error("pause error flag while option off");
endmodule : mpfc_top
`default_nettype wire

/* File: tb/mpfc_mac_model.sv */
// Transmit MAC stand-in: serves pause requests, holds packets, drives halt.
`default_nettype none
module mpfc_mac_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pkt_busy_i,
    input wire logic [3:0] ack_dly_i,
    input wire logic req_i,
    input wire logic prio_i,
    input wire logic [15:0] time_i,
    input wire logic [7:0] cls_i,
    input wire logic [127:0] times_i,
    input wire logic rx_xoff_i,
    output logic busy_o,
    output logic ack_o,
    output logic halt_o,
    output logic [7:0] nfr_o,
    output logic prio_o,
    output logic [15:0] time_o,
    output logic [7:0] cls_o,
    output logic [127:0] times_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r;
    // A packet in flight lasts as long as the bench says; it is never cut short.
    assign busy_o = pkt_busy_i;
    // The link pause receiver asks for a halt for as long as its status is up.
    assign halt_o = rx_xoff_i;
    ////////////////////////////////////////////////////////////////////////////
    // Ack after a chosen wait, one cycle long, and keep what the frame carried.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_r <= 4'h0;
            nfr_o <= 8'h00;
        end else if (ack_o) begin
            ack_o <= 1'b0;
        end else if (req_i && wait_r == ack_dly_i) begin
            ack_o <= 1'b1;
            wait_r <= 4'h0;
            nfr_o <= nfr_o + 8'h01;
            prio_o <= prio_i;
            time_o <= time_i;
            cls_o <= cls_i;
            times_o <= times_i;
        end else if (req_i) begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule : mpfc_mac_model
`default_nettype wire

/* File: tb/mpfc_top_bench.sv */
// Self-checking bench for the pause flow-control block.
`default_nettype none
module mpfc_top_bench
    import mpfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [127:0] PT = 128'h8888_7777_6666_5555_4444_3333_2222_1111;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_w, wack;
    logic [7:0] adr = 8'h00, pen = 8'h00, pxoff = 8'h00, rpen = 8'h00, rcls = 8'h00, nfr, cls, rpx, ccls;
    logic [31:0] wdat = 32'h0, rdat, wbd;
    logic strb = 1'b0, beat = 1'b0, len = 1'b0, lxoff = 1'b0, bcmd = 1'b0, rxrst = 1'b0, rlen = 1'b0;
    logic rvld = 1'b0, risp = 1'b0, eop = 1'b0, pdet = 1'b0;
    logic busy, halt, req, prio, paused, rlx, eopo, esum, cp;
    logic [15:0] biv = 16'h0, lt = 16'h1234, rtm = 16'h0, tm, ct;
    logic [127:0] rtms = 128'h0, tms, cts;
    logic [3:0] evec;
    logic [7:0] nx = 8'h00;
    int n_mismatch = 0, n_tests = 0;
    mpfc_top i_mpfc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wbd), .wb_ack_o(wack),
        .pause_send_strobe_i(strb), .beat_enable_i(beat), .beat_interval_i(biv), .link_pause_enable_i(len),
        .link_pause_time_i(lt), .prio_pause_enable_vec_i(pen), .prio_pause_time_vec_i(PT),
        .link_xoff_request_i(lxoff), .priority_xoff_request_vec_i(pxoff), .tx_halt_request_i(halt),
        .tx_frame_busy_i(busy), .pause_tx_ack_i(ack_w), .pause_tx_req_o(req), .pause_tx_prio_o(prio),
        .pause_tx_time_o(tm), .pause_tx_class_vec_o(cls), .pause_tx_times_o(tms), .tx_paused_o(paused),
        .rx_flow_ctrl_sync_reset_i(rxrst), .rx_link_pause_enable_i(rlen), .rx_priority_pause_enable_vec_i(rpen),
        .rx_pause_valid_i(rvld), .rx_pause_is_prio_i(risp), .rx_pause_time_i(rtm), .rx_pause_class_vec_i(rcls),
        .rx_pause_times_i(rtms), .rx_end_of_packet_i(eop), .rx_pause_detect_i(pdet), .rx_other_error_i(3'h0),
        .rx_link_xoff_status_o(rlx), .rx_priority_xoff_status_vec_o(rpx), .rx_end_of_packet_o(eopo),
        .rx_error_vector_o(evec), .rx_error_summary_o(esum));
    mpfc_mac_model i_mpfc_mac_model (.clk_i(clk_i), .rst_i(rst_i), .pkt_busy_i(bcmd), .ack_dly_i(4'h1),
        .req_i(req), .prio_i(prio), .time_i(tm), .cls_i(cls), .times_i(tms), .rx_xoff_i(rlx), .busy_o(busy),
        .ack_o(ack_w), .halt_o(halt), .nfr_o(nfr), .prio_o(cp), .time_o(ct), .cls_o(ccls), .times_o(cts));
    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers; the bench always resumes just after a rising edge.
    task automatic chk(input logic [127:0] e, input logic [127:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cy
    // Classic single cycle; the request is held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (wack !== 1'b1) @(posedge clk_i);
        rdat = wbd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // Pulses the send strobe, or the receive reset when r is set.
    task automatic pulse(input logic r);
        if (r) rxrst <= 1'b1;
        else strb <= 1'b1;
        @(posedge clk_i);
        rxrst <= 1'b0;
        strb <= 1'b0;
    endtask : pulse
    // Waits for the next frame and checks its kind and link time.
    task automatic frame(input logic p, input logic [15:0] t);
        nx = nx + 8'h01;
        repeat (60) if (nfr !== nx) @(posedge clk_i);
        chk(nx, nfr);
        chk(p, cp);
        if (!p) chk(t, ct);
    endtask : frame
    task automatic no_frame();
        cy(12);
        chk(nx, nfr);
    endtask : no_frame
    task automatic gap(output int k);
        logic [7:0] s;
        s = nfr;
        k = 0;
        while (nfr === s && k < 200) begin
            @(posedge clk_i);
            k++;
        end
    endtask : gap
    task automatic rx(input logic p, input logic [15:0] t, input logic [7:0] c, input logic [127:0] ts);
        rvld <= 1'b1;
        risp <= p;
        rtm <= t;
        rcls <= c;
        rtms <= ts;
        @(posedge clk_i);
        rvld <= 1'b0;
        cy(4);
    endtask : rx
    ////////////////////////////////////////////////////////////////////////////
    // Register reset values, read-only status, unmapped place.
    task automatic t_regs();
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(32'h0, rdat);
        wb(1'b1, STAT_OFS, 32'hFFFF);
        wb(1'b0, STAT_OFS, 32'h0);
        chk(32'h0, rdat);
        wb(1'b1, 8'h08, 32'hF);
        wb(1'b0, 8'h08, 32'h0);
        chk(32'h0, rdat);
        wb(1'b1, CTRL_OFS, 32'hF);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(32'hF, rdat);
    endtask : t_regs
    // Strobe, link enable and XOFF changes, also behind a busy packet.
    task automatic t_link();
        int k;
        wb(1'b1, CTRL_OFS, 32'h0);
        len <= 1'b1;
        pulse(1'b0);
        no_frame();
        wb(1'b1, CTRL_OFS, 32'hF);
        pulse(1'b0);
        frame(1'b0, lt);
        len <= 1'b0;
        lxoff <= 1'b1;
        cy(2);
        lxoff <= 1'b0;
        no_frame();
        len <= 1'b1;
        lxoff <= 1'b1;
        frame(1'b0, lt);
        lxoff <= 1'b0;
        frame(1'b0, 16'h0);
        bcmd <= 1'b1;
        lxoff <= 1'b1;
        biv <= 16'h2;
        cy(10);
        chk(1'b0, req);
        bcmd <= 1'b0;
        frame(1'b0, lt);
        beat <= 1'b1;
        gap(k);
        gap(k);
        chk(2 * QUANTUM_CYCLES + 1, k);
        chk(lt, ct);
        beat <= 1'b0;
        cy(20);
        nx = nfr;
        wb(1'b1, CTRL_OFS, 32'hD);
        beat <= 1'b1;
        cy(12);
        no_frame();
        beat <= 1'b0;
        wb(1'b1, CTRL_OFS, 32'hF);
        len <= 1'b0;
    endtask : t_link
    // Priority frames: enable vector, time slices, zero where XOFF is low.
    task automatic t_prio();
        pen <= 8'hA5;
        pxoff <= 8'h81;
        frame(1'b1, 16'h0);
        chk(8'hA5, ccls);
        chk({PT[127:112], 96'h0, PT[15:0]}, cts);
        pulse(1'b0);
        frame(1'b1, 16'h0);
        pxoff <= 8'h83;
        no_frame();
        pxoff <= 8'h01;
        frame(1'b1, 16'h0);
        chk({112'h0, PT[15:0]}, cts);
        pxoff <= 8'h00;
        frame(1'b1, 16'h0);
        chk(128'h0, cts);
        pen <= 8'h00;
    endtask : t_prio
    // Receive status, halt and paused, own reset, error flag.
    task automatic t_rx();
        rx(1'b0, 16'h3, 8'h0, 128'h0);
        chk(1'b0, rlx);
        rlen <= 1'b1;
        rx(1'b0, 16'h3, 8'h0, 128'h0);
        chk(1'b1, rlx);
        cy(2);
        chk(1'b1, paused);
        cy(22);
        chk(1'b0, rlx);
        cy(2);
        chk(1'b0, paused);
        rx(1'b0, 16'hFFFF, 8'h0, 128'h0);
        rx(1'b0, 16'h0, 8'h0, 128'h0);
        chk(1'b0, rlx);
        rx(1'b0, 16'hFFFF, 8'h0, 128'h0);
        chk(1'b1, rlx);
        pulse(1'b1);
        cy(2);
        chk(1'b0, rlx);
        rpen <= 8'h01;
        rx(1'b1, 16'h0, 8'h81, PT);
        chk(8'h01, rpx);
        rx(1'b1, 16'h0, 8'h81, 128'h0);
        chk(8'h00, rpx);
        eop <= 1'b1;
        pdet <= 1'b1;
        @(posedge clk_i);
        eop <= 1'b0;
        @(posedge clk_i);
        chk(6'h31, {eopo, esum, evec});
        @(posedge clk_i);
        pdet <= 1'b0;
        chk(4'h0, evec);
    endtask : t_rx
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run.
    task automatic close_out();
        $display("counts: tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    // Clock, reset and scenario sequence.
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        cy(6);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_link();
        t_prio();
        t_rx();
        close_out();
    end
    // A hang costs a mismatch and ends the run the normal way.
    initial begin
        cy(20000);
        n_mismatch++;
        close_out();
    end
endmodule : mpfc_top_bench
`default_nettype wire
